// file: hdl/bt1_hdr_bank.sv
// AXI4-Lite slave for the type-1 bridge header words 08h to 1Fh
// Summary of operation
// RL1: Class word returns fixed bridge class, PCI-to-PCI sub-class, zero interface byte.
// RL2: Cache line bits 2..5 are writable, reset zero, select 4 to 32 dwords.
// RL3: Cache line bits 1:0 and 7:6 are read-only zero.
// RL4: Primary latency timer writable only in reverse PCI mode; resets zero.
// RL5: Secondary latency timer writable only in forward PCI mode; resets zero.
// RL6: Header type field bits 22:16 read as one.
// RL7: Bit 23 reads zero for single function; bits 31:24 read zero.
// RL8: Primary, secondary and subordinate bus numbers are writable, reset zero.
// RL9: I/O base and limit low two bits read 01; next two read zero.
// RL10: I/O base upper nibble writable, resets zero.
// RL11: I/O limit upper nibble writable, resets zero.
// RL12: Offsets 10h to 17h are reserved and hold nothing.
// RL13: Bridge runs forward or reverse; direction shapes field access.
// RL14: Writes to read-only or reserved bits are ignored.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bt1_hdr_bank (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 reverse_pin,
  input  wire logic                 pci_mode_pin,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output bt1_pkg::bt1_cfg_s         cfg_out
);
  import bt1_pkg::*;

  typedef struct packed {
    logic        awready;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        wready;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  rd_addr;
  } bt1_axi_s;

  bt1_axi_s   st;
  bt1_axi_s   next_st;
  bt1_cfg_s   cfg;
  logic       wr_go;
  logic       wr_en;

  // Read word assembly; reserved and foreign fields read as zero
  function automatic logic [31:0] bt1_read(input bt1_cfg_s c, input logic [7:0] addr);
    logic [7:0] w;
    w = {addr[7:2], 2'b00};
    unique case (w)
      BT1_OFS_CLASS: bt1_read = {BT1_BASE_CLASS, BT1_SUB_CLASS, BT1_PROG_IF,
                                 BT1_REV_FILL}; // [RL1]
      BT1_OFS_HDR:   bt1_read = {8'h00, 1'b0, BT1_HDR_TYPE, c.pri_lat,
                                 c.line_size & BT1_LINE_WMASK}; // [RL3] [RL6] [RL7]
      BT1_OFS_BUS:   bt1_read = {c.sec_lat, c.sub_bus, c.sec_bus, c.pri_bus}; // [RL8]
      BT1_OFS_IO:    bt1_read = {16'h0000, c.io_limit, 2'b00, BT1_IO_CAP,
                                 c.io_base, 2'b00, BT1_IO_CAP}; // [RL9] [RL10] [RL11]
      BT1_OFS_MODE:  bt1_read = {29'h0, c.settled, c.pci_mode, c.reverse}; // [RL13]
      default:       bt1_read = 32'h0000_0000; // [RL12]
    endcase
  endfunction : bt1_read

  always_comb begin
    next_st = st;
    // Address and data are caught independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    wr_go = st.aw_full && st.w_full && !st.bvalid;
    wr_en = wr_go && bt1_mapped(st.aw_addr);
    if (wr_go) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = bt1_mapped(st.aw_addr) ? BT1_RESP_OKAY : BT1_RESP_DECERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
    end
    // One write in flight: both readies stay low until the answer is taken
    next_st.awready = !next_st.aw_full && !next_st.bvalid && !wr_go;
    next_st.wready  = !next_st.w_full && !next_st.bvalid && !wr_go;
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid  = 1'b1;
      next_st.rdata   = bt1_read(cfg, s_axi_araddr);
      next_st.rresp   = bt1_mapped(s_axi_araddr) ? BT1_RESP_OKAY : BT1_RESP_DECERR;
      next_st.rd_addr = {s_axi_araddr[7:2], 2'b00};
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.awready <= 1'b0;
      st.aw_full <= 1'b0;
      st.aw_addr <= 8'h00;
      st.wready  <= 1'b0;
      st.w_full  <= 1'b0;
      st.w_data  <= 32'h0000_0000;
      st.w_strb  <= 4'h0;
      st.bvalid  <= 1'b0;
      st.bresp   <= BT1_RESP_OKAY;
      st.arready <= 1'b0;
      st.rvalid  <= 1'b0;
      st.rdata   <= 32'h0000_0000;
      st.rresp   <= BT1_RESP_OKAY;
      st.rd_addr <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  bt1_cfg_core u_core (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .reverse_pin  (reverse_pin),
    .pci_mode_pin (pci_mode_pin),
    .wr_en        (wr_en),
    .wr_addr      (st.aw_addr),
    .wr_data      (st.w_data),
    .wr_strb      (st.w_strb),
    .cfg          (cfg)
  );

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign cfg_out       = cfg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read layouts of the fixed words
  property p_class;
    s_axi_rvalid && st.rd_addr == BT1_OFS_CLASS
      |-> s_axi_rdata[31:8] == 24'h060400;
  endproperty
  a_class: assert property (p_class) else $error("class code wrong"); // [RL1]

  property p_line_ro;
    s_axi_rvalid && st.rd_addr == BT1_OFS_HDR
      |-> s_axi_rdata[1:0] == 2'b00 && s_axi_rdata[7:6] == 2'b00;
  endproperty
  a_line_ro: assert property (p_line_ro) else $error("line size bits not zero"); // [RL3]

  property p_hdr;
    s_axi_rvalid && st.rd_addr == BT1_OFS_HDR |-> s_axi_rdata[31:16] == 16'h0001;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header type wrong"); // [RL6] [RL7]

  property p_rsv;
    s_axi_rvalid && (st.rd_addr == BT1_OFS_RSV0 || st.rd_addr == BT1_OFS_RSV1)
      |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == BT1_RESP_OKAY;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word not zero"); // [RL12]

  property p_io;
    s_axi_rvalid && st.rd_addr == BT1_OFS_IO
      |-> s_axi_rdata[3:0] == 4'h1 && s_axi_rdata[11:8] == 4'h1;
  endproperty
  a_io: assert property (p_io) else $error("io capability bits wrong"); // [RL9]

  // Limit nibble lands on the edge after the commit
  property p_limit;
    wr_en && {st.aw_addr[7:2], 2'b00} == BT1_OFS_IO && st.w_strb[1]
      |=> cfg.io_limit == $past(st.w_data[15:12]);
  endproperty
  a_limit: assert property (p_limit) else $error("io limit write lost"); // [RL11]

  property p_bresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late"); // [RL14]

  // The mapped set is spelt out here on purpose, so the checks do not lean on bt1_mapped
  logic        aw_known;
  logic        ar_known;
  logic [55:0] wr_fields;
  assign aw_known  = (st.aw_addr >= BT1_OFS_CLASS && st.aw_addr <= (BT1_OFS_IO | 8'h03))
                     || st.aw_addr[7:2] == BT1_OFS_MODE[7:2];
  assign ar_known  = (s_axi_araddr >= BT1_OFS_CLASS && s_axi_araddr <= (BT1_OFS_IO | 8'h03))
                     || s_axi_araddr[7:2] == BT1_OFS_MODE[7:2];
  // Every field that software can change, packed for stability checks
  assign wr_fields = {cfg.line_size, cfg.pri_lat, cfg.sec_lat, cfg.pri_bus, cfg.sec_bus,
                      cfg.sub_bus, cfg.io_base, cfg.io_limit};

  property p_reset_vals;
    $rose(aresetn) |-> wr_fields == 56'h0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // [RL8] [RL10]

  // Write path: one write at a time, answered two edges after both halves are taken
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken in answer"); // [RL14]

  property p_wr_answer;
    wr_go |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered"); // [RL14]

  property p_wr_map;
    wr_go && aw_known |=> s_axi_bresp == BT1_RESP_OKAY;
  endproperty
  a_wr_map: assert property (p_wr_map) else $error("mapped write refused"); // [RL12]

  property p_wr_unmap;
    wr_go && !aw_known |=> s_axi_bresp == BT1_RESP_DECERR && $stable(wr_fields);
  endproperty
  a_wr_unmap: assert property (p_wr_unmap) else $error("unmapped write taken"); // [RL14]

  property p_aw_take;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("address taken twice"); // [RL14]

  property p_w_take;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
  endproperty
  a_w_take: assert property (p_w_take) else $error("write data taken twice"); // [RL14]

  // Field protection: words with no writable bits must not move on a write
  property p_class_wr;
    wr_go && st.aw_addr[7:2] == BT1_OFS_CLASS[7:2] |=> $stable(wr_fields);
  endproperty
  a_class_wr: assert property (p_class_wr) else $error("class write leaked"); // [RL1] [RL14]

  property p_rsv_wr;
    wr_go && st.aw_addr >= BT1_OFS_RSV0 && st.aw_addr <= (BT1_OFS_RSV1 | 8'h03)
      |=> $stable(wr_fields);
  endproperty
  a_rsv_wr: assert property (p_rsv_wr) else $error("reserved write leaked"); // [RL12] [RL14]

  // Read path: answer one edge after the address is taken, held until rready
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken in answer"); // [RL12]

  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered"); // [RL12]

  property p_rd_map;
    s_axi_arvalid && s_axi_arready && ar_known |=> s_axi_rresp == BT1_RESP_OKAY;
  endproperty
  a_rd_map: assert property (p_rd_map) else $error("mapped read refused"); // [RL12]

  property p_rd_unmap;
    s_axi_arvalid && s_axi_arready && !ar_known
      |=> s_axi_rresp == BT1_RESP_DECERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read answered"); // [RL12]

  property p_io_hi;
    s_axi_rvalid && st.rd_addr == BT1_OFS_IO |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_io_hi: assert property (p_io_hi) else $error("io word upper half set"); // [RL9]

  property p_mode_rd;
    s_axi_rvalid && st.rd_addr == BT1_OFS_MODE |-> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("status spare bits set"); // [RL13]

  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == BT1_RESP_OKAY);
  c_read:  cover property (s_axi_rvalid && s_axi_rready && st.rd_addr == BT1_OFS_BUS);
  c_unmap: cover property (s_axi_rvalid && s_axi_rresp == BT1_RESP_DECERR);

endmodule : bt1_hdr_bank
`default_nettype wire

// file: hdl/bt1_pkg.sv
// Constants, types and helpers shared by the bridge header register bank
package bt1_pkg;

  localparam int          BT1_AW         = 8;
  localparam int          BT1_DW         = 32;

  localparam logic [7:0]  BT1_OFS_CLASS  = 8'h08;
  localparam logic [7:0]  BT1_OFS_HDR    = 8'h0c;
  localparam logic [7:0]  BT1_OFS_RSV0   = 8'h10;
  localparam logic [7:0]  BT1_OFS_RSV1   = 8'h14;
  localparam logic [7:0]  BT1_OFS_BUS    = 8'h18;
  localparam logic [7:0]  BT1_OFS_IO     = 8'h1c;
  localparam logic [7:0]  BT1_OFS_MODE   = 8'h40;

  localparam logic [7:0]  BT1_PROG_IF    = 8'h00;
  localparam logic [7:0]  BT1_SUB_CLASS  = 8'h04;
  localparam logic [7:0]  BT1_BASE_CLASS = 8'h06;
  localparam logic [7:0]  BT1_REV_FILL   = 8'h00;
  localparam logic [6:0]  BT1_HDR_TYPE   = 7'h01;
  localparam logic [7:0]  BT1_LINE_WMASK = 8'h3c;
  localparam logic [7:0]  BT1_NIB_WMASK  = 8'hf0;
  localparam logic [1:0]  BT1_IO_CAP     = 2'h1;
  localparam logic [7:0]  BT1_RST_BYTE   = 8'h00;
  localparam logic [3:0]  BT1_RST_NIB    = 4'h0;
  localparam logic [1:0]  BT1_SETTLE_CYC = 2'h2;

  localparam logic [1:0]  BT1_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  BT1_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic       settled;
    logic       reverse;
    logic       pci_mode;
    logic [7:0] line_size;
    logic [7:0] pri_lat;
    logic [7:0] sec_lat;
    logic [7:0] pri_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic [3:0] io_base;
    logic [3:0] io_limit;
  } bt1_cfg_s;

  // Byte merge that only lets the writable bits through
  function automatic logic [7:0] bt1_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic       en,
                                           input logic [7:0] wmask);
    bt1_merge = en ? ((old_v & ~wmask) | (new_v & wmask)) : old_v;
  endfunction : bt1_merge

  function automatic logic bt1_mapped(input logic [7:0] addr);
    logic [7:0] w;
    w = {addr[7:2], 2'b00};
    bt1_mapped = (w >= BT1_OFS_CLASS && w <= BT1_OFS_IO) || w == BT1_OFS_MODE;
  endfunction : bt1_mapped

endpackage : bt1_pkg

// file: hdl/bt1_cfg_core.sv
// Writable fields, direction straps and write merging of the header bank
`timescale 1ns/100ps
`default_nettype none
module bt1_cfg_core (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 reverse_pin,
  input  wire logic                 pci_mode_pin,
  input  wire logic                 wr_en,
  input  wire logic [7:0]           wr_addr,
  input  wire logic [31:0]          wr_data,
  input  wire logic [3:0]           wr_strb,
  output var  bt1_pkg::bt1_cfg_s    cfg
);
  import bt1_pkg::*;

  typedef struct packed {
    logic [1:0] rev_sync;
    logic [1:0] pci_sync;
    logic [1:0] settle;
    bt1_cfg_s   cfg;
  } bt1_core_s;

  bt1_core_s st;
  bt1_core_s next_st;
  logic      pri_lat_wr;
  logic      sec_lat_wr;
  logic [7:0] word;
  logic [7:0] base_mrg;
  logic [7:0] limit_mrg;

  always_comb begin
    next_st     = st;
    word        = {wr_addr[7:2], 2'b00};
    // Nibbles are merged as bytes so the low capability bits never take write data
    base_mrg    = bt1_merge({st.cfg.io_base, 4'h0}, wr_data[7:0], wr_strb[0],
                            BT1_NIB_WMASK);
    limit_mrg   = bt1_merge({st.cfg.io_limit, 4'h0}, wr_data[15:8], wr_strb[1],
                            BT1_NIB_WMASK);
    next_st.rev_sync = {st.rev_sync[0], reverse_pin};
    next_st.pci_sync = {st.pci_sync[0], pci_mode_pin};
    // Straps are frozen once settled so field access never flips mid-run
    if (!st.cfg.settled) begin
      if (st.settle == BT1_SETTLE_CYC) begin
        next_st.cfg.settled  = 1'b1;
        next_st.cfg.reverse  = st.rev_sync[1]; // [RL13]
        next_st.cfg.pci_mode = st.pci_sync[1];
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end
    pri_lat_wr = st.cfg.reverse && st.cfg.pci_mode;  // [RL4]
    sec_lat_wr = !st.cfg.reverse && st.cfg.pci_mode; // [RL5]
    if (wr_en) begin
      unique case (word)
        BT1_OFS_HDR: begin
          next_st.cfg.line_size = bt1_merge(st.cfg.line_size, wr_data[7:0],
                                            wr_strb[0], BT1_LINE_WMASK); // [RL2] [RL3]
          next_st.cfg.pri_lat = bt1_merge(st.cfg.pri_lat, wr_data[15:8],
                                          wr_strb[1] && pri_lat_wr, 8'hff); // [RL4] [RL14]
        end
        BT1_OFS_BUS: begin
          next_st.cfg.pri_bus = bt1_merge(st.cfg.pri_bus, wr_data[7:0], wr_strb[0], 8'hff);
          next_st.cfg.sec_bus = bt1_merge(st.cfg.sec_bus, wr_data[15:8], wr_strb[1], 8'hff);
          next_st.cfg.sub_bus = bt1_merge(st.cfg.sub_bus, wr_data[23:16], wr_strb[2],
                                          8'hff); // [RL8]
          next_st.cfg.sec_lat = bt1_merge(st.cfg.sec_lat, wr_data[31:24],
                                          wr_strb[3] && sec_lat_wr, 8'hff); // [RL5] [RL14]
        end
        BT1_OFS_IO: begin
          next_st.cfg.io_base  = base_mrg[7:4];  // [RL10] [RL9]
          next_st.cfg.io_limit = limit_mrg[7:4]; // [RL11]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.rev_sync       <= 2'h0;
      st.pci_sync       <= 2'h0;
      st.settle         <= 2'h0;
      st.cfg.settled    <= 1'b0;
      st.cfg.reverse    <= 1'b0;
      st.cfg.pci_mode   <= 1'b0;
      st.cfg.line_size  <= BT1_RST_BYTE;
      st.cfg.pri_lat    <= BT1_RST_BYTE;
      st.cfg.sec_lat    <= BT1_RST_BYTE;
      st.cfg.pri_bus    <= BT1_RST_BYTE;
      st.cfg.sec_bus    <= BT1_RST_BYTE;
      st.cfg.sub_bus    <= BT1_RST_BYTE;
      st.cfg.io_base    <= BT1_RST_NIB;
      st.cfg.io_limit   <= BT1_RST_NIB;
    end else begin
      st <= next_st;
    end
  end

  assign cfg = st.cfg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_line_wr;
    wr_en && word == BT1_OFS_HDR && wr_strb[0]
      |=> cfg.line_size == ($past(wr_data[7:0]) & BT1_LINE_WMASK);
  endproperty
  a_line_wr: assert property (p_line_wr) else $error("line size write mismatch"); // [RL2]
  property p_pri_lat_ro;
    wr_en && word == BT1_OFS_HDR && !(cfg.reverse && cfg.pci_mode) |=> $stable(cfg.pri_lat);
  endproperty
  a_pri_lat_ro: assert property (p_pri_lat_ro) else $error("primary timer wrote"); // [RL4]
  property p_sec_lat_ro;
    wr_en && word == BT1_OFS_BUS && (cfg.reverse || !cfg.pci_mode) |=> $stable(cfg.sec_lat);
  endproperty
  a_sec_lat_ro: assert property (p_sec_lat_ro) else $error("secondary timer wrote"); // [RL5]
  property p_bus_wr;
    wr_en && word == BT1_OFS_BUS && wr_strb[1] |=> cfg.sec_bus == $past(wr_data[15:8]);
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("bus number write lost"); // [RL8]
  property p_io_wr;
    wr_en && word == BT1_OFS_IO && wr_strb[0] |=> cfg.io_base == $past(wr_data[7:4]);
  endproperty
  a_io_wr: assert property (p_io_wr) else $error("io base write lost"); // [RL10]
  property p_mode_hold;
    cfg.settled |=> cfg.settled && $stable(cfg.reverse) && $stable(cfg.pci_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("direction changed"); // [RL13]
  c_rev_wr: cover property (cfg.reverse && cfg.pci_mode && wr_en && word == BT1_OFS_HDR);
  c_fwd_wr: cover property (!cfg.reverse && cfg.pci_mode && wr_en && word == BT1_OFS_BUS);

endmodule : bt1_cfg_core
`default_nettype wire

// file: tb/bt1_host_model.sv
// AXI4-Lite master standing in for configuration software on the far side
`timescale 1ns/100ps
`default_nettype none
module bt1_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Released payloads show the inverse so a stale value is never taken for a live one
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
        wstrb  <= ~s;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : read
endmodule : bt1_host_model
`default_nettype wire

// file: tb/bt1_hdr_bank_tb.sv
// Self-checking bench for the bridge header register bank
`timescale 1ns/100ps
`default_nettype none
module bt1_hdr_bank_tb;
  import bt1_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              reverse_pin = 1'b0;
  logic              pci_mode_pin = 1'b1;
  logic [7:0]        awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  bt1_cfg_s          cfg;
  int                n_errors = 0;
  int                checked = 0;

  always #20 aclk = ~aclk;

  bt1_hdr_bank i_dut (.aclk(aclk), .aresetn(aresetn), .reverse_pin(reverse_pin),
    .pci_mode_pin(pci_mode_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg_out(cfg));

  bt1_host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic test_done;
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_data(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_data

  task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_resp

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_host.read(a, d, r);
    chk_resp($sformatf("rresp@%h", a), er, r);
    chk_data($sformatf("rdata@%h", a), exp, d);
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    i_host.write(a, d, s, r);
    chk_resp($sformatf("bresp@%h", a), er, r);
  endtask : wr_chk

  // Straps are only looked at after reset, so each direction needs its own reset
  task automatic do_reset(input logic rev, input logic pci);
    @(posedge aclk);
    aresetn      <= 1'b0;
    reverse_pin  <= rev;
    pci_mode_pin <= pci;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : do_reset

  task automatic t_reset_values(input logic rev, input logic pci);
    rd_chk(BT1_OFS_CLASS, 32'h06040000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_HDR, 32'h00010000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_RSV0, 32'h00000000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_BUS, 32'h00000000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_IO, 32'h00000101, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_MODE, {29'h0, 1'b1, pci, rev}, BT1_RESP_OKAY);
    chk_data("cfg_out mode", {29'h0, 1'b1, pci, rev},
             {29'h0, cfg.settled, cfg.pci_mode, cfg.reverse});
  endtask : t_reset_values

  task automatic t_write_ones(input logic rev, input logic pci);
    logic [7:0] plat;
    logic [7:0] slat;
    plat = (rev && pci) ? 8'hff : 8'h00;
    slat = (!rev && pci) ? 8'hff : 8'h00;
    wr_chk(BT1_OFS_CLASS, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_HDR, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_RSV0, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_RSV1, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_BUS, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_IO, 32'hffffffff, 4'hf, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_CLASS, 32'h06040000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_HDR, {16'h0001, plat, 8'h3c}, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_RSV1, 32'h00000000, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_BUS, {slat, 24'hffffff}, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_IO, 32'h0000f1f1, BT1_RESP_OKAY);
    chk_data("cfg_out fields", {plat, slat, 8'h3c, 8'hff},
             {cfg.pri_lat, cfg.sec_lat, cfg.line_size, cfg.io_base, cfg.io_limit});
  endtask : t_write_ones

  task automatic t_strobes;
    wr_chk(BT1_OFS_BUS, 32'h12345678, 4'b0101, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_BUS, 32'hff34ff78, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_IO, 32'h0000a5c3, 4'b0001, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_IO + 8'h02, 32'h0000f1c1, BT1_RESP_OKAY);
    wr_chk(BT1_OFS_HDR, 32'h00000081, 4'b0001, BT1_RESP_OKAY);
    rd_chk(BT1_OFS_HDR, 32'h00010000, BT1_RESP_OKAY);
  endtask : t_strobes

  task automatic t_unmapped;
    wr_chk(8'h20, 32'hffffffff, 4'hf, BT1_RESP_DECERR);
    rd_chk(8'h20, 32'h00000000, BT1_RESP_DECERR);
    rd_chk(8'h04, 32'h00000000, BT1_RESP_DECERR);
    rd_chk(BT1_OFS_BUS, 32'hff34ff78, BT1_RESP_OKAY);
  endtask : t_unmapped

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    test_done();
  end

  initial begin
    logic [1:0] m;
    do_reset(1'b0, 1'b1);
    t_reset_values(1'b0, 1'b1);
    t_write_ones(1'b0, 1'b1);
    t_strobes();
    t_unmapped();
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      do_reset(m[1], m[0]);
      t_reset_values(m[1], m[0]);
      t_write_ones(m[1], m[0]);
    end
    test_done();
  end
endmodule : bt1_hdr_bank_tb
`default_nettype wire
